// *** hw/ddr3_mode_map.vh ***
// Constants for the DDR3 mode-register and burst-order block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
// Function
// - A3 picks sequential or interleaved order
// - A1:A0 pick BL8, on-the-fly or BC4
// - On-the-fly: A12 per command picks BC4/BL8
// - Sequential: low two bits wrap within half
// - Interleaved: beat index is start XOR count
// - BC4 read: four beats, then drivers off
// - Writes ignore start bits except A2 on BC4
// - Fixed BC4 write starts internally two clocks early when WL is over 2
// - DLL reset bit clears itself after reset
// - A12 selects slow or fast power-down exit
// - All low, BA0 high loads MR1
// - DLL off in self-refresh, on at exit
// - A1 and A5 choose driver impedance
// - Commands held for additive latency
// - MR1 A12 disconnects the data drivers
// - All low including bank bits loads MR0
`ifndef DDR3_MODE_MAP_VH
`define DDR3_MODE_MAP_VH
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_FIXED4 2'h2
`define MR0_BL_LSB 0
`define MR0_BT_BIT 3
`define MR0_CL_LSB 4
`define MR0_CL_BIT0 2
`define MR0_DLLRST_BIT 8
`define MR0_WR_LSB 9
`define MR0_PPD_BIT 12
`define MR1_DLLDIS_BIT 0
`define MR1_DIC0_BIT 1
`define MR1_DIC1_BIT 5
`define MR1_RTT0_BIT 2
`define MR1_RTT1_BIT 6
`define MR1_RTT2_BIT 9
`define MR1_AL_LSB 3
`define MR1_WLEV_BIT 7
`define MR1_QOFF_BIT 12
`define MR0_RESET 13'h0000
`define MR1_RESET 13'h0000
`define BC4_WR_EARLY 4'h2
`define DLL_RESET_CYCLES 8'h04
`define LAT_MAX 5'h1F
`endif

// *** hw/beat_order.v ***
// Column index of one beat of a burst from start bits and type.
// Pure combinational; used by the burst sequencer.
`timescale 1ns/10ps
module beat_order
(
   // Burst setup
   input wire [2:0] start_i,
   input wire interleave_i,
   // Beat number
   input wire [2:0] beat_i,
   // Column index
   output wire [2:0] col_o
);
   wire [1:0] seq_low;
   assign seq_low = start_i[1:0] + beat_i[1:0];
   assign col_o = interleave_i ? (start_i ^ beat_i)
                  : {start_i[2] ^ beat_i[2], seq_low};
endmodule

// *** hw/ddr3_mode_burst.v ***
// DDR3 mode registers MR0/MR1 and burst beat sequencing.
// Assumes command pins arrive on the same clock as plain ports; decoded here after two sync stages.
`timescale 1ns/10ps
`include "ddr3_mode_map.vh"
module ddr3_mode_burst
(
   // Clock and reset
   input wire sys_clk_i,
   input wire reset_i,
   // Command pins, sampled on this clock
   input wire cs_n_i,
   input wire ras_n_i,
   input wire cas_n_i,
   input wire we_n_i,
   input wire [2:0] ba_i,
   input wire [12:0] addr_i,
   // Power state requests
   input wire self_refresh_i,
   input wire pd_precharge_i,
   // Latency settings from MR2
   input wire [3:0] cwl_i,
   // Decoded mode fields
   output reg [2:0] cas_lat_o,
   output reg [2:0] wr_rec_o,
   output reg fast_exit_o,
   output reg [1:0] drive_sel_o,
   output reg [2:0] rtt_nom_o,
   output reg write_level_o,
   output reg dll_on_o,
   output reg dll_reset_o,
   output reg write_early_o,
   // Burst stream
   output reg beat_valid_o,
   output reg beat_write_o,
   output reg [2:0] beat_col_o,
   output reg beat_care_o,
   output reg dq_oe_o,
   output reg [4:0] read_lat_o,
   output reg [4:0] write_lat_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_BURST = 2'h2;

   reg cs_n_s1_r, cs_n_s2_r;
   reg [2:0] ctl_s1_r, ctl_s2_r;
   reg [2:0] ba_s1_r, ba_s2_r;
   reg [12:0] addr_s1_r, addr_s2_r;
   reg [1:0] pw_s1_r, pw_s2_r;
   reg [12:0] mr0_r;
   reg [12:0] mr1_r;
   reg [7:0] dll_cnt_r;
   reg [1:0] state_r;
   reg [4:0] wait_r;
   reg [2:0] beat_r;
   reg [2:0] start_r;
   reg is_write_r;
   reg chop_r;
   wire cmd_sel;
   wire mrs_cmd;
   wire rd_cmd;
   wire wr_cmd;
   wire chop_cmd;
   wire [2:0] col;
   wire [4:0] al_cyc;
   wire [4:0] rl;
   wire [4:0] wl;
   wire [2:0] ordered_start;
   wire in_sr;

   // Pin synchronisers
   always @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         cs_n_s1_r <= 1'b1;
         cs_n_s2_r <= 1'b1;
         ctl_s1_r <= 3'h7;
         ctl_s2_r <= 3'h7;
         ba_s1_r <= 3'h0;
         ba_s2_r <= 3'h0;
         addr_s1_r <= 13'h0000;
         addr_s2_r <= 13'h0000;
         pw_s1_r <= 2'h0;
         pw_s2_r <= 2'h0;
      end
      else
      begin
         cs_n_s1_r <= cs_n_i;
         cs_n_s2_r <= cs_n_s1_r;
         ctl_s1_r <= {ras_n_i, cas_n_i, we_n_i};
         ctl_s2_r <= ctl_s1_r;
         ba_s1_r <= ba_i;
         ba_s2_r <= ba_s1_r;
         addr_s1_r <= addr_i;
         addr_s2_r <= addr_s1_r;
         pw_s1_r <= {self_refresh_i, pd_precharge_i};
         pw_s2_r <= pw_s1_r;
      end
   end

   assign cmd_sel = ~cs_n_s2_r;
   assign mrs_cmd = cmd_sel && (ctl_s2_r == 3'h0);
   assign rd_cmd = cmd_sel && (ctl_s2_r == 3'h5);
   assign wr_cmd = cmd_sel && (ctl_s2_r == 3'h4);
   assign in_sr = pw_s2_r[1];

   // Burst length per command
   assign chop_cmd = (mr0_r[1:0] == `BL_FIXED4) ? 1'b1
                     : (mr0_r[1:0] == `BL_OTF) ? ~addr_s2_r[12]
                     : 1'b0;

   // Additive latency: 0, CL-1, CL-2
   assign al_cyc = (mr1_r[4:3] == 2'h1) ? {2'h0, cas_lat_o} - 5'h01
                   : (mr1_r[4:3] == 2'h2) ? {2'h0, cas_lat_o} - 5'h02 : 5'h00;
   assign rl = al_cyc + {2'h0, cas_lat_o};
   assign wl = al_cyc + {1'b0, cwl_i};

   // Write start bits: BC4 keeps only A2, BL8 none
   assign ordered_start = (wr_cmd && chop_cmd) ? {addr_s2_r[2], 2'h0}
                          : wr_cmd ? 3'h0 : addr_s2_r[2:0];

   // Mode registers
   always @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         mr0_r <= `MR0_RESET;
         mr1_r <= `MR1_RESET;
         dll_cnt_r <= 8'h00;
      end
      else
      begin
         if (mrs_cmd && ba_s2_r == 3'h0)
         begin
            mr0_r <= addr_s2_r;
            if (addr_s2_r[`MR0_DLLRST_BIT])
               dll_cnt_r <= `DLL_RESET_CYCLES;
         end
         else if (dll_cnt_r == 8'h01)
         begin
            mr0_r[`MR0_DLLRST_BIT] <= 1'b0;
            dll_cnt_r <= 8'h00;
         end
         else if (dll_cnt_r != 8'h00)
            dll_cnt_r <= dll_cnt_r - 8'h01;
         if (mrs_cmd && ba_s2_r == 3'h1)
            mr1_r <= addr_s2_r;
      end
   end

   // Decoded fields to ports
   always @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         cas_lat_o <= 3'h0;
         wr_rec_o <= 3'h0;
         fast_exit_o <= 1'b0;
         drive_sel_o <= 2'h0;
         rtt_nom_o <= 3'h0;
         write_level_o <= 1'b0;
         dll_on_o <= 1'b0;
         dll_reset_o <= 1'b0;
         write_early_o <= 1'b0;
         read_lat_o <= 5'h00;
         write_lat_o <= 5'h00;
      end
      else
      begin
         cas_lat_o <= mr0_r[`MR0_CL_LSB+2:`MR0_CL_LSB];
         wr_rec_o <= mr0_r[`MR0_WR_LSB+2:`MR0_WR_LSB];
         fast_exit_o <= mr0_r[`MR0_PPD_BIT];
         drive_sel_o <= {mr1_r[`MR1_DIC1_BIT], mr1_r[`MR1_DIC0_BIT]};
         rtt_nom_o <= {mr1_r[`MR1_RTT2_BIT], mr1_r[`MR1_RTT1_BIT], mr1_r[`MR1_RTT0_BIT]};
         write_level_o <= mr1_r[`MR1_WLEV_BIT];
         // DLL off in self-refresh or frozen in slow-exit power-down
         dll_on_o <= ~mr1_r[`MR1_DLLDIS_BIT] && ~in_sr
                     && ~(pw_s2_r[0] && ~mr0_r[`MR0_PPD_BIT]);
         dll_reset_o <= mr0_r[`MR0_DLLRST_BIT];
         write_early_o <= (mr0_r[1:0] == `BL_FIXED4);
         read_lat_o <= rl;
         write_lat_o <= wl;
      end
   end

   beat_order u_order
   (
      .start_i(start_r),
      .interleave_i(mr0_r[`MR0_BT_BIT]),
      .beat_i(beat_r),
      .col_o(col)
   );

   // Burst sequencer
   always @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_r <= ST_IDLE;
         wait_r <= 5'h00;
         beat_r <= 3'h0;
         start_r <= 3'h0;
         is_write_r <= 1'b0;
         chop_r <= 1'b0;
         beat_valid_o <= 1'b0;
         beat_write_o <= 1'b0;
         beat_col_o <= 3'h0;
         beat_care_o <= 1'b0;
         dq_oe_o <= 1'b0;
      end
      else
      begin
         beat_valid_o <= 1'b0;
         dq_oe_o <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               beat_r <= 3'h0;
               if (rd_cmd || wr_cmd)
               begin
                  start_r <= ordered_start;
                  is_write_r <= wr_cmd;
                  chop_r <= chop_cmd;
                  // Held for AL, then CL or CWL; BC4 fixed writes pulled in
                  if (wr_cmd && mr0_r[1:0] == `BL_FIXED4 && wl > {1'b0, `BC4_WR_EARLY})
                     wait_r <= wl - {1'b0, `BC4_WR_EARLY};
                  else
                     wait_r <= wr_cmd ? wl : rl;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT:
            begin
               if (wait_r <= 5'h01)
                  state_r <= ST_BURST;
               else
                  wait_r <= wait_r - 5'h01;
            end
            ST_BURST:
            begin
               beat_valid_o <= 1'b1;
               beat_write_o <= is_write_r;
               beat_col_o <= col;
               beat_care_o <= ~(chop_r && beat_r[2]);
               // Read drivers only on live beats, off when outputs disabled
               dq_oe_o <= ~is_write_r && ~(chop_r && beat_r[2])
                          && ~mr1_r[`MR1_QOFF_BIT];
               beat_r <= beat_r + 3'h1;
               if (beat_r == 3'h7)
                  state_r <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** sim/mode_burst_chk_asserts.sv ***
// Checker for ddr3_mode_burst: burst framing, beat order, DLL state.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/10ps
module mode_burst_chk
(
   input wire sys_clk_i,
   input wire reset_i,
   input wire cs_n_i,
   input wire self_refresh_i,
   input wire pd_precharge_i,
   input wire [1:0] drive_sel_o,
   input wire [2:0] rtt_nom_o,
   input wire fast_exit_o,
   input wire dll_on_o,
   input wire dll_reset_o,
   input wire beat_valid_o,
   input wire beat_write_o,
   input wire [2:0] beat_col_o,
   input wire beat_care_o,
   input wire dq_oe_o
);
   reg [2:0] idx_r;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // Beat number within the running burst
   always @(posedge sys_clk_i)
      idx_r <= (reset_i || !beat_valid_o) ? 3'h0 : idx_r + 3'h1;
   beats_run_a: assert property ($rose(beat_valid_o) |-> beat_valid_o[*8] ##1 !beat_valid_o)
      else $error("burst not eight beats");
   first_half_a: assert property (beat_valid_o && idx_r < 3'h4 |-> beat_care_o)
      else $error("first half not cared");
   half_mirror_a: assert property (beat_valid_o && beat_care_o && idx_r > 3'h3 |->
      beat_col_o == ($past(beat_col_o, 4) ^ 3'h4)) else $error("second half order");
   write_col_a: assert property (beat_valid_o && beat_write_o && beat_care_o |-> beat_col_o[1:0] == idx_r[1:0])
      else $error("write column");
   oe_live_a: assert property (dq_oe_o |-> beat_valid_o && beat_care_o && !beat_write_o)
      else $error("driver on outside read beat");
   dll_clear_a: assert property ($rose(dll_reset_o) |-> ##[1:8] !dll_reset_o)
      else $error("DLL reset stuck");
   sref_dll_a: assert property (self_refresh_i[*5] |-> !dll_on_o)
      else $error("DLL on in self refresh");
   slow_exit_a: assert property (pd_precharge_i[*5] ##0 (!fast_exit_o)[*3] |-> !dll_on_o)
      else $error("DLL on in slow power-down");
   mode_hold_a: assert property (cs_n_i[*6] |-> $stable({drive_sel_o, rtt_nom_o}))
      else $error("mode field moved");
   cover property ($rose(beat_valid_o) && beat_write_o);
   cover property (beat_valid_o && !beat_care_o);
   cover property ($rose(dll_reset_o));
endmodule
bind ddr3_mode_burst mode_burst_chk mode_burst_chk_i(.sys_clk_i, .reset_i, .cs_n_i, .self_refresh_i,
   .pd_precharge_i, .drive_sel_o, .rtt_nom_o, .fast_exit_o, .dll_on_o, .dll_reset_o, .beat_valid_o,
   .beat_write_o, .beat_col_o, .beat_care_o, .dq_oe_o);

// *** sim/ddr3_ctl_model.sv ***
// Controller model: drives the command pins for one command at a time.
// Assumes the bench calls its tasks; pins move just after rising edges.
`timescale 1ns/10ps
module ddr3_ctl_model
(
   input wire clk_i,
   output reg [3:0] cmd_n_o,
   output reg [2:0] ba_o,
   output reg [12:0] addr_o
);
   initial
   begin
      cmd_n_o = 4'hF;
      ba_o = 3'h0;
      addr_o = 13'h0000;
   end
   // One command cycle, then deselect with the address turned over
   task issue(input [3:0] c, input [2:0] b, input [12:0] a);
      @(posedge clk_i);
      cmd_n_o <= c;
      ba_o <= b;
      addr_o <= a;
      @(posedge clk_i);
      cmd_n_o <= 4'hF;
      addr_o <= ~a;
   endtask
   task mrs(input [2:0] b, input [12:0] a);
      issue(4'h0, b, (b == 3'h1) ? (a & 13'h12FF) : a);
   endtask
endmodule

// *** sim/tb.sv ***
// Testbench for ddr3_mode_burst: mode loads, burst order, DLL state.
// Assumes the controller model drives all command pins.
`timescale 1ns/10ps
module tb;
   reg sys_clk_i = 1'b0;
   reg reset_i = 1'b1;
   reg self_refresh_i = 1'b0;
   reg pd_precharge_i = 1'b0;
   reg [3:0] cwl_i = 4'h5;
   wire [3:0] cmd_n;
   wire [2:0] ba;
   wire [12:0] addr;
   wire [2:0] cas_lat_o, wr_rec_o, rtt_nom_o, beat_col_o;
   wire [1:0] drive_sel_o;
   wire [4:0] read_lat_o, write_lat_o;
   wire fast_exit_o, write_level_o, dll_on_o, dll_reset_o, write_early_o;
   wire beat_valid_o, beat_write_o, beat_care_o, dq_oe_o;
   integer bad_count = 0;
   integer total_checks = 0;
   integer k;
   always #25 sys_clk_i = ~sys_clk_i;
   ddr3_ctl_model ctl_i(.clk_i(sys_clk_i), .cmd_n_o(cmd_n), .ba_o(ba), .addr_o(addr));
   ddr3_mode_burst ddr3_mode_burst_i(.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cs_n_i(cmd_n[3]),
      .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .ba_i(ba), .addr_i(addr),
      .self_refresh_i(self_refresh_i), .pd_precharge_i(pd_precharge_i), .cwl_i(cwl_i),
      .cas_lat_o(cas_lat_o), .wr_rec_o(wr_rec_o), .fast_exit_o(fast_exit_o), .drive_sel_o(drive_sel_o),
      .rtt_nom_o(rtt_nom_o), .write_level_o(write_level_o), .dll_on_o(dll_on_o), .dll_reset_o(dll_reset_o),
      .write_early_o(write_early_o), .beat_valid_o(beat_valid_o), .beat_write_o(beat_write_o),
      .beat_col_o(beat_col_o), .beat_care_o(beat_care_o), .dq_oe_o(dq_oe_o), .read_lat_o(read_lat_o),
      .write_lat_o(write_lat_o));
   task tk(input integer n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task mr(input [2:0] b, input [12:0] a);
      ctl_i.mrs(b, a);
      tk(8);
   endtask
   // Lat is the expected hold count; two sync stages and one register come on top
   task burst(input w, input [12:0] a, input bc4, input ilv, input oe, input [4:0] lat);
      integer j;
      reg [2:0] s;
      reg live;
      s = a[2:0];
      ctl_i.issue({3'h2, !w}, 3'h0, a);
      #1;
      for (j = 0; j < 64 && beat_valid_o !== 1'b1; j = j + 1)
         tk(1);
      chk(j[7:0], 8'h03 + ((lat > 5'h01) ? {3'h0, lat} : 8'h01));
      for (j = 0; j < 8; j = j + 1)
      begin
         live = !(bc4 && j > 3);
         chk({beat_valid_o, beat_write_o, beat_care_o, dq_oe_o}, {1'b1, w, live, oe && live});
         if (!(bc4 && j > 3))
            chk(beat_col_o, w ? {bc4 ? s[2] : j[2], j[1:0]} : ilv ? s ^ j[2:0] : {s[2] ^ j[2], s[1:0] + j[1:0]});
         tk(1);
      end
   endtask
   task t_order;
      mr(3'h0, 13'h0000);
      burst(0, 13'h0005, 0, 0, 1, 5'h00);
      burst(1, 13'h0007, 0, 0, 0, 5'h05);
      mr(3'h0, 13'h0008);
      burst(0, 13'h0005, 0, 1, 1, 5'h00);
   endtask
   task t_bc4;
      mr(3'h0, 13'h0002);
      chk(write_early_o, 8'h01);
      burst(0, 13'h0006, 1, 0, 1, 5'h00);
      burst(1, 13'h0006, 1, 0, 0, 5'h03);
      mr(3'h0, 13'h0001);
      chk(write_early_o, 8'h00);
      burst(0, 13'h0001, 1, 0, 1, 5'h00);
      burst(0, 13'h1001, 0, 0, 1, 5'h00);
      burst(1, 13'h0004, 1, 0, 0, 5'h05);
   endtask
   task t_mr1;
      mr(3'h1, 13'h1286);
      chk({drive_sel_o, rtt_nom_o, write_level_o}, 8'h1B);
      burst(0, 13'h1000, 0, 0, 0, 5'h00);
      mr(3'h1, 13'h0001);
      chk({dll_on_o, rtt_nom_o}, 8'h00);
      mr(3'h1, 13'h0000);
   endtask
   task t_lat;
      mr(3'h0, 13'h0A30);
      chk({cas_lat_o, wr_rec_o}, 8'h1D);
      chk(read_lat_o, 8'h03);
      chk(write_lat_o, 8'h05);
      mr(3'h1, 13'h0008);
      chk(read_lat_o, 8'h05);
      chk(write_lat_o, 8'h07);
      burst(0, 13'h0000, 0, 0, 1, 5'h05);
      mr(3'h1, 13'h0010);
      chk(read_lat_o, 8'h04);
      chk(write_lat_o, 8'h06);
      mr(3'h1, 13'h0000);
   endtask
   task t_dll;
      chk(dll_on_o, 8'h01);
      @(posedge sys_clk_i) self_refresh_i <= 1'b1;
      tk(6);
      chk(dll_on_o, 8'h00);
      @(posedge sys_clk_i) self_refresh_i <= 1'b0;
      tk(6);
      chk(dll_on_o, 8'h01);
      @(posedge sys_clk_i) pd_precharge_i <= 1'b1;
      tk(6);
      chk(dll_on_o, 8'h00);
      ctl_i.mrs(3'h0, 13'h1100);
      for (k = 0; k < 16 && dll_reset_o !== 1'b1; k = k + 1)
         tk(1);
      chk(dll_reset_o, 8'h01);
      tk(8);
      chk({dll_reset_o, fast_exit_o, dll_on_o}, 8'h03);
      mr(3'h2, 13'h0000);
      chk(fast_exit_o, 8'h01);
      @(posedge sys_clk_i) pd_precharge_i <= 1'b0;
   endtask
   task print_verdict;
      $display("checks=%0d errors=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #200000;
      bad_count = bad_count + 1;
      print_verdict;
   end
   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_order;
      t_bc4;
      t_mr1;
      t_lat;
      t_dll;
      print_verdict;
   end
endmodule
